// ===== drar_core.sv
// drar_core: command interpreter, frame memory, address pointers, remap, contrast and scroll.
// assumes host strobes are one-cycle pulses synchronous to i_mclk; i_dc low = command/status.
`timescale 1ns/1ps
module drar_core
    import drar_pkg::*;
#(
    parameter int FRAME_COLS = 96,
    parameter int FRAME_ROWS = 64,
    parameter int PIX_W = 16
)
(
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_dc,
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    input wire logic [PIX_W-1:0] i_wdata,
    output logic [PIX_W-1:0] o_rdata,
    input wire logic i_frame_tick,
    input wire logic [COL_W-1:0] i_disp_seg,
    input wire logic [ROW_W-1:0] i_disp_row,
    output logic [PIX_W-1:0] o_disp_pixel,
    input wire logic [ROW_W-1:0] i_com_index,
    output logic [ROW_W-1:0] o_com_row,
    output logic [7:0] o_contrast_a,
    output logic [7:0] o_contrast_b,
    output logic [7:0] o_contrast_c,
    output logic [3:0] o_master_current,
    output logic [1:0] o_color_fmt,
    output logic [ROW_W-1:0] o_mux_ratio,
    output logic o_scroll_active,
    output logic [COL_W-1:0] o_hscroll_pos,
    output logic [ROW_W-1:0] o_vscroll_pos,
    output logic [ROW_W-1:0] o_scroll_row_start,
    output logic [COL_W-1:0] o_scroll_row_count
);

    if (FRAME_COLS > (1 << COL_W) || FRAME_ROWS != (1 << ROW_W) || PIX_W != 16
        || FRAME_COLS * FRAME_ROWS > (1 << ADDR_W))
    begin : g_bad_params
        $error("drar_core: frame size or pixel width not supported");
    end

    localparam logic [COL_W-1:0] LAST_COL = COL_W'(FRAME_COLS - 1);
    localparam logic [ADDR_W-1:0] COLS_A = ADDR_W'(FRAME_COLS);

    drar_state_t state;
    logic [7:0] opcode;
    logic [NPAR_W-1:0] par_left;
    logic [NPAR_W-1:0] par_idx;
    logic [7:0] pars [0:MAX_PARAMS-1];
    logic [7:0] remap;
    logic [COL_W-1:0] col_start;
    logic [COL_W-1:0] col_end;
    logic [COL_W-1:0] col_ptr;
    logic [ROW_W-1:0] row_start;
    logic [ROW_W-1:0] row_end;
    logic [ROW_W-1:0] row_ptr;
    logic [COL_W-1:0] hscroll_off;
    logic [ROW_W-1:0] vscroll_off;
    logic [1:0] scroll_intv;
    logic [7:0] frame_cnt;
    logic [PIX_W-1:0] read_latch;
    logic [PIX_W-1:0] frame_memory [0:FRAME_COLS*FRAME_ROWS-1];

    // host strobe decode; i_ce folded in so nothing moves while frozen
    wire cmd_wr = i_ce & i_wr_stb & ~i_dc;
    wire data_wr = i_ce & i_wr_stb & i_dc;
    wire data_rd = i_ce & i_rd_stb & i_dc;
    wire stat_rd = i_ce & i_rd_stb & ~i_dc;
    wire access = data_wr | data_rd;
    wire [7:0] cmd_byte = i_wdata[7:0];

    wire [NPAR_W-1:0] new_count =
        (cmd_byte == OP_SET_COL || cmd_byte == OP_SET_ROW) ? NPAR_ADDR :
        (cmd_byte == OP_SCROLL_SETUP) ? NPAR_SCROLL :
        (cmd_byte == OP_CONTRAST_A || cmd_byte == OP_CONTRAST_B || cmd_byte == OP_CONTRAST_C
         || cmd_byte == OP_MASTER_CUR || cmd_byte == OP_REMAP || cmd_byte == OP_MUX_RATIO) ? NPAR_ONE :
        NPAR_NONE;

    // apply only once the final parameter byte is on the port
    wire apply_multi = cmd_wr && state == ST_PARAMS && par_left == NPAR_ONE;
    wire apply_single = cmd_wr && state == ST_OPCODE && new_count == NPAR_NONE;

    // argument view: the last byte comes straight from the port
    logic [7:0] arg [0:MAX_PARAMS-1];
    for (genvar k = 0; k < MAX_PARAMS; k++)
    begin : g_arg
        assign arg[k] = (par_idx == NPAR_W'(k)) ? cmd_byte : pars[k];
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
        begin
            state <= ST_OPCODE;
            opcode <= 8'h00;
            par_left <= NPAR_NONE;
            par_idx <= NPAR_NONE;
        end
        else if (cmd_wr)
        begin
            case (state)
                ST_OPCODE:
                begin
                    opcode <= cmd_byte;
                    par_left <= new_count;
                    par_idx <= NPAR_NONE;
                    if (new_count != NPAR_NONE)
                        state <= ST_PARAMS;
                end
                ST_PARAMS:
                begin
                    pars[par_idx] <= cmd_byte;
                    par_idx <= par_idx + NPAR_ONE;
                    par_left <= par_left - NPAR_ONE;
                    if (par_left == NPAR_ONE)
                        state <= ST_OPCODE;
                end
                default: state <= ST_OPCODE;
            endcase
        end
    end

    // pointer movement
    wire vert_mode = remap[RM_VERT];
    wire col_at_end = col_ptr == col_end;
    wire row_at_end = row_ptr == row_end;
    wire [COL_W-1:0] col_inc = col_ptr + COL_W'(1);
    wire [ROW_W-1:0] row_inc = row_ptr + ROW_W'(1);
    wire [COL_W-1:0] next_col = vert_mode ?
        (row_at_end ? (col_at_end ? col_start : col_inc) : col_ptr) :
        (col_at_end ? col_start : col_inc);
    wire [ROW_W-1:0] next_row = vert_mode ?
        (row_at_end ? row_start : row_inc) :
        (col_at_end ? (row_at_end ? row_start : row_inc) : row_ptr);
    wire set_col = apply_multi && opcode == OP_SET_COL;
    wire set_row = apply_multi && opcode == OP_SET_ROW;

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
        begin
            col_start <= '0;
            col_end <= RST_COL_END;
            col_ptr <= '0;
            row_start <= '0;
            row_end <= RST_ROW_END;
            row_ptr <= '0;
        end
        else if (set_col)
        begin
            col_start <= arg[0][COL_W-1:0];
            col_end <= arg[1][COL_W-1:0];
            col_ptr <= arg[0][COL_W-1:0];
        end
        else if (set_row)
        begin
            row_start <= arg[0][ROW_W-1:0];
            row_end <= arg[1][ROW_W-1:0];
            row_ptr <= arg[0][ROW_W-1:0];
        end
        else if (access)
        begin
            col_ptr <= next_col;
            row_ptr <= next_row;
        end
    end

    // columns beyond the frame are not stored; reads there return zero
    wire addr_ok = col_ptr <= LAST_COL;
    wire [ADDR_W-1:0] mem_addr = ADDR_W'(row_ptr) * COLS_A + ADDR_W'(col_ptr);

    always_ff @(posedge i_mclk)
    begin
        if (data_wr && addr_ok)
            frame_memory[mem_addr] <= i_wdata;
    end

    // a read returns what the previous read fetched, hence the dummy read
    wire [PIX_W-1:0] status_word = PIX_W'({state == ST_PARAMS, o_scroll_active});
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
        begin
            o_rdata <= '0;
            read_latch <= '0;
        end
        else if (data_rd)
        begin
            o_rdata <= read_latch;
            read_latch <= addr_ok ? frame_memory[mem_addr] : '0;
        end
        else if (stat_rd)
            o_rdata <= status_word;
    end

    // configuration registers
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
        begin
            remap <= RST_REMAP;
            o_contrast_a <= RST_CONTRAST;
            o_contrast_b <= RST_CONTRAST;
            o_contrast_c <= RST_CONTRAST;
            o_master_current <= RST_MASTER;
            o_mux_ratio <= FULL_MUX;
            hscroll_off <= '0;
            o_scroll_row_start <= '0;
            o_scroll_row_count <= '0;
            vscroll_off <= '0;
            scroll_intv <= 2'h0;
            o_scroll_active <= 1'b0;
        end
        else if (apply_multi)
        begin
            case (opcode)
                OP_CONTRAST_A: o_contrast_a <= arg[0];
                OP_CONTRAST_B: o_contrast_b <= arg[0];
                OP_CONTRAST_C: o_contrast_c <= arg[0];
                OP_MASTER_CUR: o_master_current <= arg[0][3:0];
                OP_REMAP: remap <= arg[0];
                OP_MUX_RATIO: o_mux_ratio <= arg[0][ROW_W-1:0];
                OP_SCROLL_SETUP:
                begin
                    hscroll_off <= arg[0][COL_W-1:0];
                    o_scroll_row_start <= arg[1][ROW_W-1:0];
                    o_scroll_row_count <= arg[2][COL_W-1:0];
                    vscroll_off <= arg[3][ROW_W-1:0];
                    scroll_intv <= arg[4][1:0];
                end
                default: remap <= remap;
            endcase
        end
        else if (apply_single)
        begin
            if (cmd_byte == OP_SCROLL_STOP)
                o_scroll_active <= 1'b0;
            else if (cmd_byte == OP_SCROLL_START)
                o_scroll_active <= 1'b1;
        end
    end

    assign o_color_fmt = remap[RM_FMT_HI:RM_FMT_LO];

    // scroll engine, stepped by display frame ticks
    wire [7:0] intv_frames = (scroll_intv == 2'h0) ? INTV_SEL0 :
                             (scroll_intv == 2'h1) ? INTV_SEL1 :
                             (scroll_intv == 2'h2) ? INTV_SEL2 : INTV_SEL3;
    wire mux_full = o_mux_ratio == FULL_MUX;
    wire scroll_step = o_scroll_active && i_ce && i_frame_tick && frame_cnt == intv_frames - 8'h01;
    wire [COL_W:0] hsum = {1'b0, o_hscroll_pos} + {1'b0, hscroll_off};
    wire [COL_W:0] hwrap = hsum - (COL_W+1)'(FRAME_COLS);
    wire [COL_W-1:0] next_hpos = (hsum >= (COL_W+1)'(FRAME_COLS)) ? hwrap[COL_W-1:0] : hsum[COL_W-1:0];

    // stopping also rewinds the positions so the panel shows unshifted memory
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
        begin
            frame_cnt <= 8'h00;
            o_hscroll_pos <= '0;
            o_vscroll_pos <= '0;
        end
        else if (i_ce && !o_scroll_active)
        begin
            frame_cnt <= 8'h00;
            o_hscroll_pos <= '0;
            o_vscroll_pos <= '0;
        end
        else if (i_ce && i_frame_tick)
        begin
            frame_cnt <= scroll_step ? 8'h00 : frame_cnt + 8'h01;
            if (scroll_step)
            begin
                o_hscroll_pos <= next_hpos;
                if (mux_full)
                    o_vscroll_pos <= o_vscroll_pos + vscroll_off;
            end
        end
    end

    // segment side readout: column mirror and colour order swap
    wire [COL_W-1:0] seg_col = remap[RM_COL_REV] ? LAST_COL - i_disp_seg : i_disp_seg;
    wire seg_ok = seg_col <= LAST_COL;
    wire [ADDR_W-1:0] disp_addr = ADDR_W'(i_disp_row) * COLS_A + ADDR_W'(seg_col);
    wire [PIX_W-1:0] disp_raw = seg_ok ? frame_memory[disp_addr] : '0;
    wire [PIX_W-1:0] disp_swapped = {disp_raw[4:0], disp_raw[10:5], disp_raw[15:11]};

    // common side: lr swap flips the half, split interleaves, reverse mirrors
    wire [ROW_W-1:0] com_half = i_com_index ^ {remap[RM_COM_LR], {(ROW_W-1){1'b0}}};
    wire [ROW_W-1:0] com_split = remap[RM_COM_SPLIT] ?
        {com_half[ROW_W-2:0], com_half[ROW_W-1]} : com_half;
    wire [ROW_W-1:0] com_map = remap[RM_COM_REV] ? ~com_split : com_split;

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
        begin
            o_disp_pixel <= '0;
            o_com_row <= '0;
        end
        else if (i_ce)
        begin
            o_disp_pixel <= remap[RM_RGB_SWAP] ? disp_swapped : disp_raw;
            o_com_row <= com_map;
        end
    end

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);

    sequence stop_cmd;
        apply_single && cmd_byte == OP_SCROLL_STOP;
    endsequence
    sequence start_cmd;
        apply_single && cmd_byte == OP_SCROLL_START;
    endsequence

    ptr_hold_a: assert property (cmd_wr && !set_col && !set_row |=> $stable(col_ptr) && $stable(row_ptr))
        else $error("pointer moved on a command byte");
    col_wrap_a: assert property (access && !vert_mode && col_at_end |=> col_ptr == $past(col_start))
        else $error("column did not wrap to start");
    row_step_a: assert property (access && !vert_mode && col_at_end && !row_at_end
        |=> row_ptr == $past(row_ptr) + ROW_W'(1))
        else $error("row did not step at end column");
    vert_step_a: assert property (access && vert_mode && !row_at_end
        |=> row_ptr == $past(row_ptr) + ROW_W'(1) && $stable(col_ptr))
        else $error("vertical mode step wrong");
    col_load_a: assert property (set_col |=> col_ptr == col_start && col_end == $past(arg[1][COL_W-1:0]))
        else $error("column bounds not loaded");
    master_reset_a: assert property ($rose(i_rst_b) |-> o_master_current == RST_MASTER)
        else $error("master current reset value wrong");
    scroll_ctrl_a: assert property ((stop_cmd |=> !o_scroll_active) and (start_cmd |=> o_scroll_active))
        else $error("scroll start or stop ignored");
    vscroll_mux_a: assert property (o_vscroll_pos != $past(o_vscroll_pos) && $past(o_scroll_active)
        |-> $past(mux_full))
        else $error("vertical scroll ran without full multiplex");
    com_rev_a: assert property (i_ce && remap[RM_COM_SPLIT:RM_COM_LR] == 3'h2 |=> o_com_row == ~$past(i_com_index))
        else $error("reversed common scan mapping wrong");
    stat_hold_a: assert property (stat_rd |=> $stable(col_ptr) && $stable(row_ptr))
        else $error("pointer moved on a status read");
    row_load_a: assert property (set_row |=> row_ptr == row_start && row_end == $past(arg[1][ROW_W-1:0]))
        else $error("row bounds not loaded");
    freeze_hold_a: assert property (!i_ce |=> $stable(state) && $stable(col_ptr) && $stable(o_scroll_active))
        else $error("state moved while clock enable low");

endmodule // drar_core

// ===== drar_core_tb_top.sv
// drar_core_tb_top: self-checking bench for the frame memory access and remap block.
// assumes drar_host_model drives the host port; the bench drives the display side itself.
`timescale 1ns/1ps
module drar_core_tb_top
    import drar_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic ce, dc, wr, rd, sact;
    logic tick;
    logic [15:0] wdata, rdata, pix;
    logic [6:0] seg;
    logic [6:0] hpos, rcount;
    logic [5:0] drow;
    logic [5:0] comi;
    logic [5:0] com_row, mux, vpos, rstart;
    logic [7:0] ca, cb, cc;
    logic [3:0] mc;
    logic [1:0] fmt;
    int err_count = 0;
    int num_checks = 0;

    always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

    drar_host_model u_host (.i_mclk(mclk), .i_rdata(rdata), .o_ce(ce), .o_dc(dc), .o_wr_stb(wr),
        .o_rd_stb(rd), .o_wdata(wdata));

    drar_core u_dut (.i_mclk(mclk), .i_rst_b(rst_b),
        .i_ce(ce), .i_dc(dc), .i_wr_stb(wr), .i_rd_stb(rd), .i_wdata(wdata), .o_rdata(rdata),
        .i_frame_tick(tick), .i_disp_seg(seg), .i_disp_row(drow), .o_disp_pixel(pix),
        .i_com_index(comi), .o_com_row(com_row), .o_contrast_a(ca), .o_contrast_b(cb),
        .o_contrast_c(cc), .o_master_current(mc), .o_color_fmt(fmt), .o_mux_ratio(mux),
        .o_scroll_active(sact), .o_hscroll_pos(hpos), .o_vscroll_pos(vpos),
        .o_scroll_row_start(rstart), .o_scroll_row_count(rcount));

    task automatic chk_data(input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic chk_cfg(input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    function automatic logic [7:0] cur(input int i);
        case (i)
            0: cur = ca;
            1: cur = cb;
            2: cur = cc;
            default: cur = {4'h0, mc};
        endcase
    endfunction

    task automatic set_win(input logic [7:0] c0, c1, r0, r1);
        u_host.cmd(OP_SET_COL);
        u_host.cmd(c0);
        u_host.cmd(c1);
        u_host.cmd(OP_SET_ROW);
        u_host.cmd(r0);
        u_host.cmd(r1);
    endtask

    task automatic tick_once();
        @(posedge mclk);
        tick <= 1'b1;
        @(posedge mclk);
        tick <= 1'b0;
        @(posedge mclk);
        #1;
    endtask

    task automatic t_reset();
        chk_cfg(8'h80, ca);
        chk_cfg(8'h0F, {4'h0, mc});
        chk_cfg(8'h01, {6'h00, fmt});
        chk_cfg(8'h00, {7'h00, sact});
        chk_cfg(8'h3F, {2'b00, mux});
        $display("test reset done");
    endtask

    task automatic t_contrast();
        logic [7:0] v;
        logic [7:0] op;
        for (int k = 0; k < 2; k++)
        begin
            v = (k == 0) ? 8'hFF : 8'h00;
            for (int i = 0; i < 4; i++)
            begin
                op = (i == 3) ? OP_MASTER_CUR : OP_CONTRAST_A + 8'(i);
                u_host.cmd(op);
                u_host.idle();
                chk_cfg((i == 3) ? 8'h0F : ((k == 0) ? 8'h80 : 8'hFF), cur(i));
                u_host.cmd(v);
                u_host.idle();
                chk_cfg((i == 3) ? {4'h0, v[3:0]} : v, cur(i));
            end
        end
        $display("test contrast done");
    endtask

    task automatic t_freeze();
        logic [15:0] s;
        u_host.hold_ce(OP_CONTRAST_A);
        u_host.hold_ce(8'h11);
        u_host.idle();
        chk_cfg(8'h00, ca);
        u_host.fetch(1'b0, s);
        chk_data(16'h0000, s);
        $display("test freeze done");
    endtask

    task automatic t_window();
        logic [15:0] s;
        u_host.cmd(OP_MASTER_CUR);
        u_host.fetch(1'b0, s);
        chk_data(16'h0002, s);
        u_host.cmd(8'h0F);
        u_host.cmd(OP_REMAP);
        u_host.cmd(8'h40);
        set_win(8'h02, 8'h04, 8'h01, 8'h02);
        for (int j = 0; j < 7; j++)
        begin
            u_host.send(1'b1, 16'hA000 + 16'(j));
            if (j == 1)
            begin
                u_host.fetch(1'b0, s);
                chk_data(16'h0000, s);
            end
        end
        set_win(8'h02, 8'h04, 8'h01, 8'h02);
        u_host.dummy_read();
        for (int j = 0; j < 6; j++)
        begin
            u_host.fetch(1'b1, s);
            chk_data((j == 0) ? 16'hA006 : 16'hA000 + 16'(j), s);
        end
        u_host.cmd(OP_REMAP);
        u_host.cmd(8'h41);
        set_win(8'h00, 8'h01, 8'h00, 8'h02);
        for (int j = 0; j < 6; j++)
            u_host.send(1'b1, 16'hB000 + 16'(j));
        u_host.cmd(OP_REMAP);
        u_host.cmd(8'h40);
        set_win(8'h00, 8'h01, 8'h00, 8'h02);
        u_host.dummy_read();
        for (int j = 0; j < 6; j++)
        begin
            u_host.fetch(1'b1, s);
            chk_data(16'hB000 + 16'((j % 2) * 3 + j / 2), s);
        end
        u_host.idle();
        $display("test window done");
    endtask

    task automatic t_remap();
        logic [7:0] a0 [5] = '{8'h40, 8'h42, 8'h42, 8'h44, 8'h40};
        logic [6:0] sg [5] = '{7'h00, 7'h00, 7'h5F, 7'h00, 7'h02};
        logic [5:0] dr [5] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h01};
        logic [15:0] ex [5] = '{16'h1234, 16'h8421, 16'h1234, 16'hA222, 16'hA006};
        set_win(8'h5F, 8'h5F, 8'h00, 8'h00);
        u_host.send(1'b1, 16'h8421);
        set_win(8'h00, 8'h00, 8'h00, 8'h00);
        u_host.send(1'b1, 16'h1234);
        for (int i = 0; i < 5; i++)
        begin
            u_host.cmd(OP_REMAP);
            u_host.cmd(a0[i]);
            u_host.idle();
            @(posedge mclk);
            seg <= sg[i];
            drow <= dr[i];
            repeat (2) @(posedge mclk);
            #1 chk_data(ex[i], pix);
        end
        $display("test remap done");
    endtask

    task automatic t_com();
        logic [7:0] a0 [4] = '{8'h00, 8'h08, 8'h50, 8'hA0};
        logic [5:0] ex [4] = '{6'h03, 6'h23, 6'h3C, 6'h06};
        comi <= 6'h03;
        for (int i = 0; i < 4; i++)
        begin
            u_host.cmd(OP_REMAP);
            u_host.cmd(a0[i]);
            u_host.idle();
            chk_cfg({2'b00, ex[i]}, {2'b00, com_row});
            chk_cfg({6'h00, a0[i][7:6]}, {6'h00, fmt});
        end
        u_host.cmd(OP_REMAP);
        u_host.cmd(8'h40);
        $display("test com done");
    endtask

    task automatic t_scroll();
        logic [15:0] s;
        logic [6:0] ho [4] = '{7'h5F, 7'h00, 7'h01, 7'h02};
        logic [5:0] vo [4] = '{6'h3F, 6'h01, 6'h00, 6'h05};
        logic [5:0] mx [4] = '{6'h3F, 6'h3F, 6'h3F, 6'h2F};
        logic [5:0] ev [4] = '{6'h3F, 6'h01, 6'h00, 6'h00};
        int n [4] = '{6, 10, 100, 200};
        for (int i = 0; i < 4; i++)
        begin
            u_host.cmd(OP_MUX_RATIO);
            u_host.cmd({2'b00, mx[i]});
            u_host.scroll_setup(ho[i], 6'h00, 7'h40, vo[i], 2'(i));
            u_host.cmd(OP_SCROLL_START);
            u_host.fetch(1'b0, s);
            chk_data(16'h0001, s);
            chk_cfg(8'h40, {1'b0, rcount} | {2'b00, rstart});
            chk_cfg({2'b00, mx[i]}, {2'b00, mux});
            repeat (n[i] - 1) tick_once();
            chk_cfg(8'h00, {1'b0, hpos});
            tick_once();
            chk_cfg({1'b0, ho[i]}, {1'b0, hpos});
            chk_cfg({2'b00, ev[i]}, {2'b00, vpos});
            u_host.cmd(OP_SCROLL_STOP);
            u_host.idle();
            chk_cfg(8'h00, {7'h00, sact} | {1'b0, hpos});
        end
        $display("test scroll done");
    endtask

    initial
    begin
        repeat (100000) @(posedge mclk);
        err_count++;
        summarize();
    end

    initial
    begin
        tick <= 1'b0;
        seg <= 7'h00;
        drow <= 6'h00;
        comi <= 6'h00;
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset();
        t_contrast();
        t_freeze();
        t_window();
        t_remap();
        t_com();
        t_scroll();
        summarize();
    end
endmodule // drar_core_tb_top

// ===== drar_host_model.sv
// drar_host_model: host microcontroller on the parallel port of drar_core.
// assumes one clock shared with the core; every request moves right after a rising edge.
`timescale 1ns/1ps
module drar_host_model
    import drar_pkg::*;
(
    input wire logic i_mclk,
    input wire logic [15:0] i_rdata,
    output logic o_ce,
    output logic o_dc,
    output logic o_wr_stb,
    output logic o_rd_stb,
    output logic [15:0] o_wdata
);
    initial
    begin
        o_ce = 1'b1;
        o_dc = 1'b0;
        o_wr_stb = 1'b0;
        o_rd_stb = 1'b0;
        o_wdata = 16'h0000;
    end

    // strobe stays up across back-to-back writes so no signal is assigned twice in one step
    task automatic send(input logic dc, input logic [15:0] data);
        @(posedge i_mclk);
        o_dc <= dc;
        o_wr_stb <= 1'b1;
        o_rd_stb <= 1'b0;
        o_wdata <= data;
    endtask

    task automatic fetch(input logic dc, output logic [15:0] data);
        @(posedge i_mclk);
        o_dc <= dc;
        o_rd_stb <= 1'b1;
        o_wr_stb <= 1'b0;
        @(posedge i_mclk);
        o_rd_stb <= 1'b0;
        #1 data = i_rdata;
    endtask

    task automatic idle();
        @(posedge i_mclk);
        o_wr_stb <= 1'b0;
        o_rd_stb <= 1'b0;
        o_wdata <= ~o_wdata;
        @(posedge i_mclk);
        #1;
    endtask

    // a command byte offered while the clock enable is low must be ignored
    task automatic hold_ce(input logic [7:0] b);
        @(posedge i_mclk);
        o_ce <= 1'b0;
        o_dc <= 1'b0;
        o_wr_stb <= 1'b1;
        o_rd_stb <= 1'b0;
        o_wdata <= {8'h00, b};
        @(posedge i_mclk);
        o_ce <= 1'b1;
        o_wr_stb <= 1'b0;
    endtask

    task automatic cmd(input logic [7:0] b);
        send(1'b0, {8'h00, b});
    endtask

    task automatic dummy_read();
        logic [15:0] junk;
        fetch(1'b1, junk);
    endtask

    task automatic scroll_setup(input logic [6:0] hoff, input logic [5:0] start, input logic [6:0] rows,
        input logic [5:0] voff, input logic [1:0] intv);
        logic [6:0] fit;
        // a host never asks for rows past the bottom of the panel
        fit = ({2'b00, start} + {1'b0, rows} > 8'h40) ? 7'h40 - {1'b0, start} : rows;
        cmd(OP_SCROLL_SETUP);
        cmd({1'b0, hoff});
        cmd({2'b00, start});
        cmd({1'b0, fit});
        cmd({2'b00, voff});
        cmd({6'h00, intv});
    endtask
endmodule // drar_host_model

// ===== drar_pkg.sv
// drar_pkg: constants shared by the frame memory access and remap block.
// assumes one 125 MHz clock domain and a host byte/word port on the same clock.
package drar_pkg;
    localparam int COL_W = 7;
    localparam int ROW_W = 6;
    localparam int ADDR_W = 13;
    localparam int NPAR_W = 3;
    localparam int CLK_PERIOD_NS = 8;

    // opcodes
    localparam logic [7:0] OP_SET_COL = 8'h15;
    localparam logic [7:0] OP_SET_ROW = 8'h75;
    localparam logic [7:0] OP_CONTRAST_A = 8'h81;
    localparam logic [7:0] OP_CONTRAST_B = 8'h82;
    localparam logic [7:0] OP_CONTRAST_C = 8'h83;
    localparam logic [7:0] OP_MASTER_CUR = 8'h87;
    localparam logic [7:0] OP_REMAP = 8'hA0;
    localparam logic [7:0] OP_MUX_RATIO = 8'hA8;
    localparam logic [7:0] OP_SCROLL_SETUP = 8'h27;
    localparam logic [7:0] OP_SCROLL_STOP = 8'h2E;
    localparam logic [7:0] OP_SCROLL_START = 8'h2F;

    // parameter byte counts
    localparam logic [NPAR_W-1:0] NPAR_NONE = 3'h0;
    localparam logic [NPAR_W-1:0] NPAR_ONE = 3'h1;
    localparam logic [NPAR_W-1:0] NPAR_ADDR = 3'h2;
    localparam logic [NPAR_W-1:0] NPAR_SCROLL = 3'h5;
    localparam int MAX_PARAMS = 5;

    // remap and data format bit positions
    localparam int RM_VERT = 0;
    localparam int RM_COL_REV = 1;
    localparam int RM_RGB_SWAP = 2;
    localparam int RM_COM_LR = 3;
    localparam int RM_COM_REV = 4;
    localparam int RM_COM_SPLIT = 5;
    localparam int RM_FMT_LO = 6;
    localparam int RM_FMT_HI = 7;

    // reset values
    localparam logic [7:0] RST_REMAP = 8'h40;
    localparam logic [7:0] RST_CONTRAST = 8'h80;
    localparam logic [3:0] RST_MASTER = 4'hF;
    localparam logic [ROW_W-1:0] FULL_MUX = 6'h3F;
    localparam logic [COL_W-1:0] RST_COL_END = 7'h5F;
    localparam logic [ROW_W-1:0] RST_ROW_END = 6'h3F;

    // frames between scroll steps
    localparam logic [7:0] INTV_SEL0 = 8'h06;
    localparam logic [7:0] INTV_SEL1 = 8'h0A;
    localparam logic [7:0] INTV_SEL2 = 8'h64;
    localparam logic [7:0] INTV_SEL3 = 8'hC8;

    // status word bits
    localparam int STS_SCROLL = 0;
    localparam int STS_PARAM_WAIT = 1;

    typedef enum logic {ST_OPCODE, ST_PARAMS} drar_state_t;
endpackage
